// ===== verilog/wakdet_pkg.sv
// Constants for the wake input detector
package wakdet_pkg;
   localparam int NUM_WAKE = 3;
   localparam int NUM_ALT = 2;
   localparam logic [3:0] ADDR_ENABLE = 4'h0;
   localparam logic [3:0] ADDR_FILTER = 4'h1;
   localparam logic [3:0] ADDR_PULL = 4'h2;
   localparam logic [3:0] ADDR_SOURCE = 4'h3;
   localparam logic [3:0] ADDR_ALT_STAT = 4'h4;
   localparam logic [3:0] ADDR_LEVEL = 4'h5;
   localparam logic [3:0] ADDR_MASK = 4'h6;
   localparam logic [3:0] ADDR_ALT_CFG = 4'h7;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [2:0] ENABLE_RESET = 3'h0;
   localparam logic [5:0] FILTER_RESET = 6'h00;
   localparam logic [5:0] PULL_RESET = 6'h00;
   localparam logic [4:0] MASK_RESET = 5'h00;
   localparam logic [1:0] ALT_CFG_RESET = 2'h0;
   localparam logic [1:0] FLT_STATIC_16 = 2'h0;
   localparam logic [1:0] FLT_STATIC_64 = 2'h1;
   localparam logic [1:0] FLT_CYCLIC_A = 2'h2;
   localparam logic [1:0] FLT_CYCLIC_B = 2'h3;
   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_DOWN = 2'h1;
   localparam logic [1:0] PULL_UP = 2'h2;
   localparam logic [1:0] PULL_AUTO = 2'h3;
   localparam int CLK_MHZ = 250;
   localparam int FILTER_SHORT_US = 16;
   localparam int FILTER_LONG_US = 64;
   localparam int FILT_SHORT_CYC = FILTER_SHORT_US * CLK_MHZ;
   localparam int FILT_LONG_CYC = FILTER_LONG_US * CLK_MHZ;
   localparam int FILT_CNT_W = 14;
   typedef enum logic [1:0] {
      MODE_ACTIVE, MODE_HALTED, MODE_SLEEP, MODE_FAILSAFE
   } wakdet_mode_type;
endpackage : wakdet_pkg

// ===== verilog/wakdet_top.sv
// Wake input detector: sync, deglitch, edge events, status and irq
//
// Overview of operation
// - Three wake inputs, each a thresholded digital level from a comparator.
// - Enabled input gives an event on both rising and falling filtered edges.
// - Event raises interrupt in active/halted mode, wake-up in sleep/failsafe.
// - Static sensing evaluates the detection path continuously.
// - Cyclic sensing detects only during the assigned timer on-window.
// - Cyclic sensing uses either cyclic timer A or cyclic timer B.
// - Static filter time selectable as 16 us or 64 us per input.
// - Filter starts on level change; event only if level stays stable.
// - Per-input software enable bit decides whether events can wake.
// - Per-input wake source flag records which input caused a wake.
// - Pin levels readable in active and halted modes.
// - Level reported even for inputs with wake enable cleared.
// - In cyclic sensing level register holds last on-window sample.
// - Alternate pins as wake inputs: static 16 us, own status register.
// - Each of the three wake inputs has software-selected pull-up and pull-down sources; alternate pins have none.
// - Filter field: 00 static16, 01 static64, 10 cyclic A, 11 cyclic B.
// - Pull field: 00 none, 01 down, 10 up, 11 automatic by level.
`timescale 1ns/1ns
`default_nettype none
module wakdet_top (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Comparator outputs of wake pins and alternate-function pins
   input wire logic [2:0] wake_pin_in,
   input wire logic [1:0] alt_function_pins_in,
   // Cyclic timer on-windows
   input wire logic cyclic_timer_a_in,
   input wire logic cyclic_timer_b_in,
   // Operating mode of the device
   input wire logic [1:0] mode_in,
   // Register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Pull current source controls
   output logic [2:0] pull_up_en_out,
   output logic [2:0] pull_down_en_out,
   // Event outputs
   output logic irq_out,
   output logic wake_req_out
);

   logic [2:0] wake_enable_control_reg;
   logic [5:0] filter_select_field_reg;
   logic [5:0] pull_select_field_reg;
   logic [4:0] mask_reg;
   logic [1:0] alt_cfg_reg;
   logic [2:0] wake_source_status_reg;
   logic [1:0] alt_pin_wake_status_reg;
   logic [2:0] pin_level_status_reg;
   logic [7:0] reg_rdata_reg;
   logic wake_req_reg;
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic [4:0] stable_reg;
   logic [4:0] event_pulse;
   logic [4:0] sense_active;
   logic [4:0] enable_vec;
   wakdet_pkg::wakdet_mode_type mode;
   logic run_mode;
   logic rd_source;
   logic rd_alt;

   assign mode = wakdet_pkg::wakdet_mode_type'(mode_in);
   // Active and halted modes report by interrupt, others by wake
   assign run_mode = (mode == wakdet_pkg::MODE_ACTIVE) ||
                     (mode == wakdet_pkg::MODE_HALTED);
   assign rd_source = reg_rd_in && (reg_addr_in == wakdet_pkg::ADDR_SOURCE);
   assign rd_alt = reg_rd_in && (reg_addr_in == wakdet_pkg::ADDR_ALT_STAT);
   assign enable_vec = {alt_cfg_reg, wake_enable_control_reg};

   // Two-stage synchroniser for all five comparator outputs
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sync1_reg <= 5'h00;
         sync2_reg <= 5'h00;
      end else begin
         sync1_reg <= {alt_function_pins_in, wake_pin_in};
         sync2_reg <= sync1_reg;
      end
   end

   // Per-input deglitch filter and edge detector
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_chan
         logic [wakdet_pkg::FILT_CNT_W-1:0] cnt_reg;
         logic [wakdet_pkg::FILT_CNT_W-1:0] limit;
         logic [1:0] flt;
         logic timing_reg;
         if (gi < 3) begin : g_main
            assign flt = filter_select_field_reg[2*gi +: 2];
         end else begin : g_alt
            // Alternate pins are fixed to static 16 us
            assign flt = wakdet_pkg::FLT_STATIC_16;
         end
         assign limit = (flt == wakdet_pkg::FLT_STATIC_64) ?
            wakdet_pkg::FILT_CNT_W'(wakdet_pkg::FILT_LONG_CYC - 1) :
            wakdet_pkg::FILT_CNT_W'(wakdet_pkg::FILT_SHORT_CYC - 1);
         // Cyclic modes only look during the chosen timer on-window
         always_comb begin
            case (flt)
               wakdet_pkg::FLT_CYCLIC_A: sense_active[gi] = cyclic_timer_a_in;
               wakdet_pkg::FLT_CYCLIC_B: sense_active[gi] = cyclic_timer_b_in;
               default: sense_active[gi] = 1'b1;
            endcase
         end
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               cnt_reg <= '0;
               timing_reg <= 1'b0;
               stable_reg[gi] <= 1'b0;
            end else if (!sense_active[gi]) begin
               // Window closed: abandon a half-timed change
               cnt_reg <= '0;
               timing_reg <= 1'b0;
            end else if (sync2_reg[gi] == stable_reg[gi]) begin
               // Level crossed back before expiry: glitch dropped
               cnt_reg <= '0;
               timing_reg <= 1'b0;
            end else if (cnt_reg == limit) begin
               cnt_reg <= '0;
               timing_reg <= 1'b0;
               stable_reg[gi] <= sync2_reg[gi];
            end else begin
               cnt_reg <= cnt_reg + 1'b1;
               timing_reg <= 1'b1;
            end
         end
         // Either direction of an accepted change is an event
         assign event_pulse[gi] = sense_active[gi] && enable_vec[gi] &&
            (sync2_reg[gi] != stable_reg[gi]) &&
            (cnt_reg == limit);
      end
   endgenerate

   // Pull source steering, automatic follows the filtered level
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_pull
         logic [1:0] psel;
         assign psel = pull_select_field_reg[2*gi +: 2];
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               pull_up_en_out[gi] <= 1'b0;
               pull_down_en_out[gi] <= 1'b0;
            end else begin
               pull_up_en_out[gi] <= (psel == wakdet_pkg::PULL_UP) ||
                  ((psel == wakdet_pkg::PULL_AUTO) && stable_reg[gi]);
               pull_down_en_out[gi] <= (psel == wakdet_pkg::PULL_DOWN) ||
                  ((psel == wakdet_pkg::PULL_AUTO) && !stable_reg[gi]);
            end
         end
      end
   endgenerate

   // Configuration registers
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wake_enable_control_reg <= wakdet_pkg::ENABLE_RESET;
         filter_select_field_reg <= wakdet_pkg::FILTER_RESET;
         pull_select_field_reg <= wakdet_pkg::PULL_RESET;
         mask_reg <= wakdet_pkg::MASK_RESET;
         alt_cfg_reg <= wakdet_pkg::ALT_CFG_RESET;
      end else if (reg_wr_in) begin
         if (reg_addr_in == wakdet_pkg::ADDR_ENABLE) begin
            wake_enable_control_reg <= reg_wdata_in[2:0];
         end else if (reg_addr_in == wakdet_pkg::ADDR_FILTER) begin
            filter_select_field_reg <= reg_wdata_in[5:0];
         end else if (reg_addr_in == wakdet_pkg::ADDR_PULL) begin
            pull_select_field_reg <= reg_wdata_in[5:0];
         end else if (reg_addr_in == wakdet_pkg::ADDR_MASK) begin
            mask_reg <= reg_wdata_in[4:0];
         end else if (reg_addr_in == wakdet_pkg::ADDR_ALT_CFG) begin
            alt_cfg_reg <= reg_wdata_in[1:0];
         end
      end
   end

   // Sticky wake sources; a new event wins over the read clear
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wake_source_status_reg <= 3'h0;
         alt_pin_wake_status_reg <= 2'h0;
      end else begin
         wake_source_status_reg <= (rd_source ? 3'h0 : wake_source_status_reg)
            | event_pulse[2:0];
         alt_pin_wake_status_reg <= (rd_alt ? 2'h0 : alt_pin_wake_status_reg)
            | event_pulse[4:3];
      end
   end

   // Level status: live level in static, window sample in cyclic
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_lvl
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               pin_level_status_reg[gi] <= 1'b0;
            end else if (run_mode && sense_active[gi]) begin
               // Updated regardless of the wake enable bit
               pin_level_status_reg[gi] <= sync2_reg[gi];
            end
         end
      end
   endgenerate

   // Wake request holds until the device leaves the low-power mode
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wake_req_reg <= 1'b0;
      end else if (run_mode) begin
         wake_req_reg <= 1'b0;
      end else if (|event_pulse) begin
         wake_req_reg <= 1'b1;
      end
   end

   assign wake_req_out = wake_req_reg;
   assign irq_out = run_mode && |({alt_pin_wake_status_reg,
      wake_source_status_reg} & mask_reg);

   // Read data, one cycle after the strobe
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_rdata_reg <= wakdet_pkg::UNMAPPED_READ;
      end else if (reg_rd_in) begin
         if (reg_addr_in == wakdet_pkg::ADDR_ENABLE) begin
            reg_rdata_reg <= {5'h00, wake_enable_control_reg};
         end else if (reg_addr_in == wakdet_pkg::ADDR_FILTER) begin
            reg_rdata_reg <= {2'h0, filter_select_field_reg};
         end else if (reg_addr_in == wakdet_pkg::ADDR_PULL) begin
            reg_rdata_reg <= {2'h0, pull_select_field_reg};
         end else if (reg_addr_in == wakdet_pkg::ADDR_SOURCE) begin
            reg_rdata_reg <= {5'h00, wake_source_status_reg};
         end else if (reg_addr_in == wakdet_pkg::ADDR_ALT_STAT) begin
            reg_rdata_reg <= {6'h00, alt_pin_wake_status_reg};
         end else if (reg_addr_in == wakdet_pkg::ADDR_LEVEL) begin
            reg_rdata_reg <= {5'h00, pin_level_status_reg};
         end else if (reg_addr_in == wakdet_pkg::ADDR_MASK) begin
            reg_rdata_reg <= {3'h0, mask_reg};
         end else if (reg_addr_in == wakdet_pkg::ADDR_ALT_CFG) begin
            reg_rdata_reg <= {6'h00, alt_cfg_reg};
         end else begin
            reg_rdata_reg <= wakdet_pkg::UNMAPPED_READ;
         end
      end else begin
         reg_rdata_reg <= wakdet_pkg::UNMAPPED_READ;
      end
   end

   assign reg_rdata_out = reg_rdata_reg;

endmodule : wakdet_top
`default_nettype wire

// ===== tb/wakdet_switch_model.sv
// Model of external switches wired to the wake pins
`timescale 1ns/1ns
`default_nettype none
module wakdet_switch_model (
   // Switch state set by the bench
   input wire logic [2:0] drive_en_in,
   input wire logic [2:0] drive_lvl_in,
   // Pull sources from the detector
   input wire logic [2:0] pull_up_in,
   input wire logic [2:0] pull_down_in,
   // Level at the comparators
   output logic [2:0] pin_out
);
   // Open switch with no pull: pin drifts away from last level
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (drive_en_in[i]) pin_out[i] = drive_lvl_in[i];
         else if (pull_up_in[i]) pin_out[i] = 1'b1;
         else if (pull_down_in[i]) pin_out[i] = 1'b0;
         else pin_out[i] = ~drive_lvl_in[i];
      end
   end
endmodule : wakdet_switch_model
`default_nettype wire

// ===== tb/wakdet_top_sva.sv
// Port checker of the wake input detector
`timescale 1ns/1ns
`default_nettype none
module wakdet_top_sva (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Watched ports
   input wire logic [2:0] wake_pin_in,
   input wire logic [1:0] mode_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [2:0] pull_up_en_out,
   input wire logic [2:0] pull_down_en_out,
   input wire logic irq_out,
   input wire logic wake_req_out
);
   logic [13:0] quiet_reg;
   logic [2:0] pin_reg;
   // Cycles since any pin moved; other pins moving hides a cause
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         quiet_reg <= 14'h0000;
         pin_reg <= 3'h0;
      end else begin
         pin_reg <= wake_pin_in;
         if (pin_reg != wake_pin_in) quiet_reg <= 14'h0000;
         else if (quiet_reg != 14'h3FFF) quiet_reg <= quiet_reg + 14'h0001;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data not idle");
   chk_unmapped_read: assert property (reg_rd_in && reg_addr_in > 4'h7
      |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
   chk_level_width: assert property (reg_rd_in && reg_addr_in == 4'h5
      |=> reg_rdata_out[7:3] == 5'h00) else $error("level read too wide");
   chk_irq_run_only: assert property (irq_out |-> mode_in < 2'h2)
      else $error("irq outside run mode");
   chk_wake_clear: assert property (mode_in < 2'h2 |=> !wake_req_out)
      else $error("wake request not cleared");
   chk_wake_sticky: assert property (wake_req_out && mode_in > 2'h1
      |=> wake_req_out) else $error("wake request dropped");
   chk_wake_filtered: assert property ($rose(wake_req_out) |->
      $past(mode_in) > 2'h1 && quiet_reg >= 14'h0FA0)
      else $error("wake without filtered pin event");
   chk_pull_excl: assert property (!(|(pull_up_en_out & pull_down_en_out)))
      else $error("pull up and down together");
endmodule : wakdet_top_sva
bind wakdet_top wakdet_top_sva wakdet_top_sva_i (.clk_in(clk_in),
   .resetn_in(resetn_in), .wake_pin_in(wake_pin_in), .mode_in(mode_in),
   .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .pull_up_en_out(pull_up_en_out),
   .pull_down_en_out(pull_down_en_out), .irq_out(irq_out),
   .wake_req_out(wake_req_out));
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench of the wake input detector
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk_in, resetn_in, tma, tmb, wr, rd, irq, wreq;
   logic [2:0] lvl, pin, pu, pd, den;
   logic [1:0] alt, mode;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   wakdet_switch_model wakdet_switch_model_i (.drive_en_in(den),
      .drive_lvl_in(lvl), .pull_up_in(pu), .pull_down_in(pd), .pin_out(pin));
   wakdet_top wakdet_top_i (.clk_in(clk_in), .resetn_in(resetn_in),
      .wake_pin_in(pin), .alt_function_pins_in(alt), .cyclic_timer_a_in(tma),
      .cyclic_timer_b_in(tmb), .mode_in(mode), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .pull_up_en_out(pu), .pull_down_en_out(pd),
      .irq_out(irq), .wake_req_out(wreq));
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // Run is about 70k cycles
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         err_total++;
         final_report();
      end
   end
   task wt(input int n);
      repeat (n) @(posedge clk_in);
   endtask : wt
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask : chk
   task wreg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_in);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask : wreg
   // Data stand only in the cycle after the strobe
   task rchk(input logic [3:0] a, input logic [7:0] e, input string n);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      @(posedge clk_in);
      chk(n, e, rdata);
   endtask : rchk
   task src(input logic [7:0] e);
      rchk(wakdet_pkg::ADDR_SOURCE, e, "source");
   endtask : src
   task ow(input logic [1:0] e);
      @(posedge clk_in);
      chk("wake irq", {6'h00, e}, {6'h00, wreq, irq});
   endtask : ow
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   task t_static;
      rchk(4'hC, 8'h00, "unmapped");
      rchk(wakdet_pkg::ADDR_FILTER, 8'h00, "filter");
      wreg(wakdet_pkg::ADDR_ENABLE, 8'h07);
      wreg(wakdet_pkg::ADDR_MASK, 8'h1E);
      lvl[0] <= 1'b1;
      wt(2000);
      lvl[0] <= 1'b0;
      wt(4100);
      src(8'h00);
      lvl[0] <= 1'b1;
      wt(3950);
      src(8'h00);
      wt(100);
      ow(2'b00);
      wreg(wakdet_pkg::ADDR_MASK, 8'h1F);
      ow(2'b01);
      src(8'h01);
      ow(2'b00);
      lvl[0] <= 1'b0;
      wt(4100);
      src(8'h01);
      wreg(wakdet_pkg::ADDR_FILTER, 8'h04);
      lvl[1] <= 1'b1;
      wt(10000);
      src(8'h00);
      wt(6100);
      src(8'h02);
      wreg(wakdet_pkg::ADDR_ENABLE, 8'h03);
      lvl[2] <= 1'b1;
      wt(4100);
      src(8'h00);
      rchk(wakdet_pkg::ADDR_LEVEL, 8'h06, "level");
      wreg(wakdet_pkg::ADDR_ENABLE, 8'h07);
      $display("static sensing test done");
   endtask : t_static
   task t_cyclic;
      wreg(wakdet_pkg::ADDR_FILTER, 8'h0E);
      lvl[0] <= 1'b1;
      lvl[1] <= 1'b0;
      wt(4100);
      src(8'h00);
      rchk(wakdet_pkg::ADDR_LEVEL, 8'h06, "level");
      tmb <= 1'b1;
      wt(4100);
      src(8'h02);
      tmb <= 1'b0;
      tma <= 1'b1;
      wt(4100);
      src(8'h01);
      tma <= 1'b0;
      rchk(wakdet_pkg::ADDR_LEVEL, 8'h05, "level");
      wreg(wakdet_pkg::ADDR_FILTER, 8'h00);
      $display("cyclic sensing test done");
   endtask : t_cyclic
   task t_modes;
      for (int m = 0; m < 4; m++) begin
         mode <= m[1:0];
         lvl[0] <= ~lvl[0];
         wt(4100);
         ow({m > 1, m < 2});
         mode <= 2'h0;
         wt(2);
         src(8'h01);
      end
      wreg(wakdet_pkg::ADDR_ALT_CFG, 8'h03);
      alt[0] <= 1'b1;
      wt(4100);
      ow(2'b01);
      rchk(wakdet_pkg::ADDR_ALT_STAT, 8'h01, "alt status");
      ow(2'b00);
      // Pin 0 is high here, so automatic picks the pull-up
      for (int c = 0; c < 4; c++) begin
         wreg(wakdet_pkg::ADDR_PULL, c[7:0]);
         wt(4);
         chk("pull", {6'h00, c == 1, c > 1}, {6'h00, pd[0], pu[0]});
      end
      // Open switch 0: only the pull-down now sets the pin level
      wreg(wakdet_pkg::ADDR_PULL, 8'h01);
      den[0] <= 1'b0;
      wt(4100);
      src(8'h01);
      rchk(wakdet_pkg::ADDR_LEVEL, 8'h04, "pulled level");
      $display("mode alt and pull test done");
   endtask : t_modes
   initial begin
      {lvl, alt, mode, tma, tmb, wr, rd, addr, wdata} = '0;
      den = 3'h7;
      resetn_in = 1'b0;
      wt(20);
      resetn_in <= 1'b1;
      t_static();
      t_cyclic();
      t_modes();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
